/* File: verilog/bridge_cfg_pkg.sv */
// Constants and carrier types for the primary configuration header block.
// Assumes byte addresses in configuration space and a 32-bit data path.
package bridge_cfg_pkg;

    // Configuration dword offsets, as byte addresses.
    localparam logic [7:0] CMD_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CLASS_REV_OFFSET = 8'h08;

    // Command register field positions.
    localparam int CMD_PALETTE_SNOOP_BIT = 5;
    localparam int CMD_PARITY_RESP_BIT = 6;
    localparam int CMD_WAIT_CYCLE_BIT = 7;
    localparam int CMD_SERR_ENABLE_BIT = 8;
    localparam int CMD_FAST_B2B_BIT = 9;

    // Status register field positions in the upper half of the dword.
    localparam int STAT_CAP_LIST_BIT = 20;
    localparam int STAT_66MHZ_BIT = 21;
    localparam int STAT_FAST_B2B_BIT = 23;
    localparam int STAT_DATA_PAR_RPT_BIT = 24;
    localparam int STAT_DEVSEL_LSB = 25;
    localparam int STAT_SIG_TGT_ABORT_BIT = 27;
    localparam int STAT_RCV_TGT_ABORT_BIT = 28;
    localparam int STAT_RCV_MST_ABORT_BIT = 29;
    localparam int STAT_SIG_SYS_ERR_BIT = 30;
    localparam int STAT_DET_PAR_ERR_BIT = 31;

    // Sticky status flags, index order within the flag vector.
    localparam int FLAG_COUNT = 6;
    localparam int FLAG_DATA_PAR_RPT = 0;
    localparam int FLAG_SIG_TGT_ABORT = 1;
    localparam int FLAG_RCV_TGT_ABORT = 2;
    localparam int FLAG_RCV_MST_ABORT = 3;
    localparam int FLAG_SIG_SYS_ERR = 4;
    localparam int FLAG_DET_PAR_ERR = 5;

    // Reset and constant field values.
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0] PROG_IF_CODE = 8'h00;
    localparam logic [7:0] SUBCLASS_BRIDGE = 8'h04;
    localparam logic [7:0] BASE_CLASS_BRIDGE = 8'h06;
    localparam logic CMD_BIT_RESET = 1'h0;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 6'h00;

    // Palette port addresses, compared on address bits 9:0.
    localparam logic [9:0] PALETTE_PORT_A = 10'h3c6;
    localparam logic [9:0] PALETTE_PORT_B = 10'h3c8;
    localparam logic [9:0] PALETTE_PORT_C = 10'h3c9;
    localparam int PALETTE_LOW_MSB = 9;
    localparam int PALETTE_ZERO_LSB = 16;

    // One configuration access from the primary bus.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] byte_en_n;
        logic [31:0] wdata;
    } cfg_req_s;

    // Primary interface events reported by the bridge core.
    typedef struct packed {
        logic master_active;
        logic data_par_err;
        logic addr_par_err;
        logic tgt_abort_signaled;
        logic tgt_abort_received;
        logic master_abort_received;
    } pri_event_s;

    // One I/O write seen on the primary bus.
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic in_io_window;
    } io_write_s;

endpackage

/* File: verilog/sticky_flags.sv */
// A vector of sticky status flags with write-one-to-clear.
// Assumes set and clear arrive on sys_clk; set wins over clear.
`timescale 1ns/1ns

module sticky_flags (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [bridge_cfg_pkg::FLAG_COUNT-1:0] set_vec,
    input wire logic [bridge_cfg_pkg::FLAG_COUNT-1:0] clear_vec,
    output logic [bridge_cfg_pkg::FLAG_COUNT-1:0] flags
);

    // Each flag is held independently; a set in the clear cycle survives.
    for (genvar i = 0; i < bridge_cfg_pkg::FLAG_COUNT; i++) begin : g_flag
        logic flag_reg;
        logic flag_next;
        // RULE_08 one clears
        assign flag_next = set_vec[i] | (flag_reg & ~clear_vec[i]);
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                flag_reg <= bridge_cfg_pkg::FLAGS_RESET[i];
            end else begin
                flag_reg <= flag_next;
            end
        end
        assign flags[i] = flag_reg;
    end

endmodule // sticky_flags

/* File: verilog/palette_snoop.sv */
// Palette write decode and claim for primary I/O writes.
// Assumes the I/O write request is a one-cycle strobe on sys_clk.
`timescale 1ns/1ns

module palette_snoop (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic snoop_enable,
    input wire bridge_cfg_pkg::io_write_s io_write,
    output logic claim
);

    logic is_palette;
    logic low_match;
    logic high_zero;
    logic claim_reg;
    logic claim_next;

    // RULE_01 palette address decode
    assign low_match =
        (io_write.addr[bridge_cfg_pkg::PALETTE_LOW_MSB:0] ==
         bridge_cfg_pkg::PALETTE_PORT_A) ||
        (io_write.addr[bridge_cfg_pkg::PALETTE_LOW_MSB:0] ==
         bridge_cfg_pkg::PALETTE_PORT_B) ||
        (io_write.addr[bridge_cfg_pkg::PALETTE_LOW_MSB:0] ==
         bridge_cfg_pkg::PALETTE_PORT_C);
    assign high_zero =
        (io_write.addr[31:bridge_cfg_pkg::PALETTE_ZERO_LSB] == 16'h0000);
    assign is_palette = low_match && high_zero;

    // RULE_02 snoop claim
    assign claim_next = io_write.valid &&
        ((is_palette && snoop_enable) || io_write.in_io_window);

    // The claim is a registered one-cycle pulse.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            claim_reg <= 1'h0;
        end else begin
            claim_reg <= claim_next;
        end
    end

    assign claim = claim_reg;

endmodule // palette_snoop

/* File: verilog/bridge_primary_config_header.sv */
// Command, status and class-code registers of the bridge primary side.
// Assumes configuration accesses and events arrive on sys_clk; the parity
// error pin comes from the bus and is synchronised here.
`timescale 1ns/1ns

// Overview of operation
// RULE_01 - Palette write: I/O address 9:0 is 3C6h/3C8h/3C9h, bits 31:16 zero.
// RULE_02 - Snoop bit set claims palette writes; clear claims only window hits.
// RULE_03 - Parity response clear: no PERR drive, no reported bit, no SERR.
// RULE_04 - Parity response set: drive PERR on data errors, allow SERR.
// RULE_05 - Wait cycle control bit reads zero and ignores writes.
// RULE_06 - SERR enable gates every drive of the system error pin.
// RULE_07 - Fast back-to-back enable and command bits 15:10 read zero.
// RULE_08 - Status error flags clear on written one, keep on zero.
// RULE_09 - Status bits 20, 21, 23 read one; 19:16 and 22 read zero.
// RULE_10 - Bit 24 sets as master on parity error with response enabled.
// RULE_11 - Target-select timing field reads medium encoding 01b.
// RULE_12 - Bit 27 sets when the bridge signals a target abort.
// RULE_13 - Bit 28 sets when the bridge receives a target abort.
// RULE_14 - Bit 29 sets when the bridge's own cycle master-aborts.
// RULE_15 - Bit 30 sets whenever the bridge drives the system error pin.
// RULE_16 - Bit 31 sets on any primary parity error regardless of enables.
// RULE_17 - Revision byte at dword 08h bits 7:0 is read-only.
// RULE_18 - Programming interface byte reads zero.
// RULE_19 - Subclass byte reads the bridge-to-bridge code.
// RULE_20 - Base class byte reads the bridge class code.
// RULE_21 - Writes touch only enabled bytes; reads return the whole dword.
module bridge_primary_config_header #(
    // Silicon revision; the value is arbitrary.
    parameter logic [7:0] SILICON_REVISION = 8'h2a
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire bridge_cfg_pkg::cfg_req_s cfg_req,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire bridge_cfg_pkg::pri_event_s pri_event,
    input wire bridge_cfg_pkg::io_write_s io_write,
    output logic palette_claim,
    input wire logic primary_parity_err_pin_in,
    output logic primary_parity_err_pin_out,
    output logic primary_parity_err_pin_oe,
    output logic primary_system_err_pin_out,
    output logic primary_system_err_pin_oe,
    output logic palette_snoop_en,
    output logic parity_resp_en,
    output logic serr_en
);

    // Command bits, pin drives and the answer of the register port.
    logic snoop_reg;
    logic snoop_next;
    logic parity_resp_reg;
    logic parity_resp_next;
    logic serr_en_reg;
    logic serr_en_next;
    logic perr_meta_reg;
    logic perr_sync_reg;
    logic perr_oe_reg;
    logic perr_oe_next;
    logic serr_oe_reg;
    logic serr_oe_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic hit_cmd_status;
    logic hit_class_rev;
    logic cfg_wr;
    logic lane0_wr;
    logic lane1_wr;
    logic lane3_wr;
    logic [15:0] command_view;
    logic [15:0] status_view;
    logic [31:0] class_rev_view;
    logic [bridge_cfg_pkg::FLAG_COUNT-1:0] flag_set;
    logic [bridge_cfg_pkg::FLAG_COUNT-1:0] flag_clear;
    logic [bridge_cfg_pkg::FLAG_COUNT-1:0] flags;
    logic perr_seen;
    logic perr_pin_low;
    logic cfg_rd;
    logic [31:0] read_word;
    logic perr_out_reg;
    logic serr_out_reg;

    // Address decode on the dword; the low two address bits are ignored.
    // Only the two dwords of this block decode; all others read zero.
    assign hit_cmd_status =
        (cfg_req.addr[7:2] == bridge_cfg_pkg::CMD_STATUS_OFFSET[7:2]);
    assign hit_class_rev =
        (cfg_req.addr[7:2] == bridge_cfg_pkg::CLASS_REV_OFFSET[7:2]);
    assign cfg_wr = cfg_req.valid && cfg_req.write && hit_cmd_status;

    // Byte enables are active low, one per lane of the dword.
    // RULE_21 byte enable gating
    assign lane0_wr = cfg_wr && !cfg_req.byte_en_n[0];
    assign lane1_wr = cfg_wr && !cfg_req.byte_en_n[1];
    assign lane3_wr = cfg_wr && !cfg_req.byte_en_n[3];

    // Writable command bits take new values only on their enabled lane.
    // Bits 7 and 9 have no flip-flop, so writes can never reach them.
    assign snoop_next = lane0_wr ?
        cfg_req.wdata[bridge_cfg_pkg::CMD_PALETTE_SNOOP_BIT] : snoop_reg;
    assign parity_resp_next = lane0_wr ?
        cfg_req.wdata[bridge_cfg_pkg::CMD_PARITY_RESP_BIT] : parity_resp_reg;
    assign serr_en_next = lane1_wr ?
        cfg_req.wdata[bridge_cfg_pkg::CMD_SERR_ENABLE_BIT] : serr_en_reg;

    // Command bits held in flip-flops.
    // All of them reset to zero, which leaves both error pins undriven.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            snoop_reg <= bridge_cfg_pkg::CMD_BIT_RESET;
            parity_resp_reg <= bridge_cfg_pkg::CMD_BIT_RESET;
            serr_en_reg <= bridge_cfg_pkg::CMD_BIT_RESET;
        end else begin
            snoop_reg <= snoop_next;
            parity_resp_reg <= parity_resp_next;
            serr_en_reg <= serr_en_next;
        end
    end

    // Two-stage synchroniser for the parity error pin from the bus.
    // Both stages reset to the idle high level, so leaving reset never
    // looks like a parity error reported by another agent.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            perr_meta_reg <= 1'h1;
            perr_sync_reg <= 1'h1;
        end else begin
            perr_meta_reg <= primary_parity_err_pin_in;
            perr_sync_reg <= perr_meta_reg;
        end
    end

    // RULE_03 parity response gating
    // RULE_04 drive parity pin
    assign perr_oe_next = pri_event.data_par_err && parity_resp_reg;

    // RULE_06 system error gate
    assign serr_oe_next = pri_event.addr_par_err && parity_resp_reg &&
        serr_en_reg;

    // Pin drives last one cycle per detected error.
    // Only the enables move; the driven level stays low.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            perr_oe_reg <= 1'h0;
            serr_oe_reg <= 1'h0;
        end else begin
            perr_oe_reg <= perr_oe_next;
            serr_oe_reg <= serr_oe_next;
        end
    end

    // Level put on the open-drain pins while enabled. Both pins are
    // active low, so the level is always low; it sits in a flip-flop so
    // that every pin output of the block leaves a register.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            perr_out_reg <= 1'h0;
            serr_out_reg <= 1'h0;
        end else begin
            perr_out_reg <= 1'h0;
            serr_out_reg <= 1'h0;
        end
    end

    // The pin is seen asserted two cycles late through the synchroniser.
    assign perr_pin_low = !perr_sync_reg;

    // The parity pin is low while sampled asserted or while driven by us.
    // Our own data parity error counts at once, without waiting for the
    // pin to come back through the synchroniser.
    assign perr_seen = perr_pin_low || pri_event.data_par_err;

    // Each set term is a pulse or a level judged within one cycle.
    // RULE_10 data parity reported
    assign flag_set[bridge_cfg_pkg::FLAG_DATA_PAR_RPT] =
        pri_event.master_active && perr_seen && parity_resp_reg;
    // RULE_12 signaled target abort
    assign flag_set[bridge_cfg_pkg::FLAG_SIG_TGT_ABORT] =
        pri_event.tgt_abort_signaled;
    // RULE_13 received target abort
    assign flag_set[bridge_cfg_pkg::FLAG_RCV_TGT_ABORT] =
        pri_event.tgt_abort_received;
    // RULE_14 received master abort
    assign flag_set[bridge_cfg_pkg::FLAG_RCV_MST_ABORT] =
        pri_event.master_abort_received;
    // RULE_15 signaled system error
    assign flag_set[bridge_cfg_pkg::FLAG_SIG_SYS_ERR] = serr_oe_reg;
    // RULE_16 detected parity error
    assign flag_set[bridge_cfg_pkg::FLAG_DET_PAR_ERR] =
        pri_event.addr_par_err || pri_event.data_par_err;

    // A clear needs the status byte lane enabled and a one in the bit.
    // RULE_08 write one clears
    assign flag_clear[bridge_cfg_pkg::FLAG_DATA_PAR_RPT] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_DATA_PAR_RPT_BIT];
    assign flag_clear[bridge_cfg_pkg::FLAG_SIG_TGT_ABORT] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_SIG_TGT_ABORT_BIT];
    assign flag_clear[bridge_cfg_pkg::FLAG_RCV_TGT_ABORT] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_RCV_TGT_ABORT_BIT];
    assign flag_clear[bridge_cfg_pkg::FLAG_RCV_MST_ABORT] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_RCV_MST_ABORT_BIT];
    assign flag_clear[bridge_cfg_pkg::FLAG_SIG_SYS_ERR] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_SIG_SYS_ERR_BIT];
    assign flag_clear[bridge_cfg_pkg::FLAG_DET_PAR_ERR] = lane3_wr &&
        cfg_req.wdata[bridge_cfg_pkg::STAT_DET_PAR_ERR_BIT];

    // Sticky error flags of the status register.
    // A set wins over a clear in the same cycle, so no event is lost.
    sticky_flags u_flags (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .set_vec(flag_set),
        .clear_vec(flag_clear),
        .flags(flags)
    );

    // Palette write claim towards the forwarding logic.
    // The claim is registered inside, one cycle after the I/O write.
    palette_snoop u_palette (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .snoop_enable(snoop_reg),
        .io_write(io_write),
        .claim(palette_claim)
    );

    // Command fields listed from bit 15 down to bit 0.
    // RULE_05 wait cycle zero
    // RULE_07 reserved command zero
    assign command_view = {
        6'h00,
        1'h0,
        serr_en_reg,
        1'h0,
        parity_resp_reg,
        snoop_reg,
        5'h00
    };

    // Status fields listed from bit 31 down to bit 16.
    // RULE_09 constant capability bits
    // RULE_11 medium select timing
    assign status_view = {
        flags[bridge_cfg_pkg::FLAG_DET_PAR_ERR],
        flags[bridge_cfg_pkg::FLAG_SIG_SYS_ERR],
        flags[bridge_cfg_pkg::FLAG_RCV_MST_ABORT],
        flags[bridge_cfg_pkg::FLAG_RCV_TGT_ABORT],
        flags[bridge_cfg_pkg::FLAG_SIG_TGT_ABORT],
        bridge_cfg_pkg::DEVSEL_MEDIUM,
        flags[bridge_cfg_pkg::FLAG_DATA_PAR_RPT],
        1'h1,
        1'h0,
        1'h1,
        1'h1,
        4'h0
    };

    // Class fields listed from bit 31 down to bit 0.
    // RULE_17 revision byte
    // RULE_18 programming interface zero
    // RULE_19 bridge subclass
    // RULE_20 bridge base class
    assign class_rev_view = {
        bridge_cfg_pkg::BASE_CLASS_BRIDGE,
        bridge_cfg_pkg::SUBCLASS_BRIDGE,
        bridge_cfg_pkg::PROG_IF_CODE,
        SILICON_REVISION
    };

    // Read word of the addressed dword; unmapped dwords read zero.
    assign cfg_rd = cfg_req.valid && !cfg_req.write;
    assign read_word = hit_cmd_status ? {status_view, command_view} :
        hit_class_rev ? class_rev_view : 32'h0000_0000;

    // RULE_21 whole dword read
    // A write loads zero so that stale read data never looks like an answer.
    assign rdata_next = !cfg_req.valid ? rdata_reg :
        cfg_rd ? read_word : 32'h0000_0000;

    // Every access is answered one cycle later; unmapped reads give zero.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ack_reg <= 1'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= cfg_req.valid;
            rdata_reg <= rdata_next;
        end
    end

    // Every output leaves a flip-flop directly.
    assign cfg_ack = ack_reg;
    assign cfg_rdata = rdata_reg;
    assign primary_parity_err_pin_out = perr_out_reg;
    assign primary_parity_err_pin_oe = perr_oe_reg;
    assign primary_system_err_pin_out = serr_out_reg;
    assign primary_system_err_pin_oe = serr_oe_reg;
    assign palette_snoop_en = snoop_reg;
    assign parity_resp_en = parity_resp_reg;
    assign serr_en = serr_en_reg;

endmodule // bridge_primary_config_header

/* File: sim/bridge_cfg_checker.sv */
// Concurrent checks on the ports of the primary configuration header block.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/1ns

module bridge_cfg_checker #(
    parameter logic [7:0] SILICON_REVISION = 8'h2a
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire bridge_cfg_pkg::cfg_req_s cfg_req,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire bridge_cfg_pkg::pri_event_s pri_event,
    input wire bridge_cfg_pkg::io_write_s io_write,
    input wire logic palette_claim,
    input wire logic primary_parity_err_pin_in,
    input wire logic primary_parity_err_pin_out,
    input wire logic primary_parity_err_pin_oe,
    input wire logic primary_system_err_pin_out,
    input wire logic primary_system_err_pin_oe,
    input wire logic palette_snoop_en,
    input wire logic parity_resp_en,
    input wire logic serr_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Decoded causes that the outputs must follow.
    wire rd_cmd = cfg_req.valid && !cfg_req.write
        && cfg_req.addr[7:2] == 6'h01;
    wire rd_cls = cfg_req.valid && !cfg_req.write
        && cfg_req.addr[7:2] == 6'h02;
    wire wr_l1 = cfg_req.valid && cfg_req.write && cfg_req.addr[7:2] == 6'h01
        && !cfg_req.byte_en_n[1];
    wire pe_hit = pri_event.data_par_err && parity_resp_en;
    wire se_hit = pri_event.addr_par_err && parity_resp_en && serr_en;
    wire pal_port = io_write.addr[9:0] == 10'h3c6
        || io_write.addr[9:0] == 10'h3c8 || io_write.addr[9:0] == 10'h3c9;
    wire pal_hit = io_write.valid && (io_write.in_io_window
        || palette_snoop_en && io_write.addr[31:16] == 16'h0 && pal_port);

    chk_ack_next: assert property (cfg_req.valid |=> cfg_ack)
        else $error("config answer missing");
    chk_ack_cause: assert property (
        cfg_ack |-> $past(cfg_req.valid))
        else $error("config answer without request");
    chk_cmd_fixed: assert property (
        rd_cmd |=> cfg_rdata[15:9] == 7'h0
        && !cfg_rdata[7] && cfg_rdata[23:16] == 8'hb0
        && cfg_rdata[26:25] == 2'h1 && cfg_rdata[5] == $past(palette_snoop_en))
        else $error("command or status constant bits wrong");
    chk_class_word: assert property (rd_cls |=> cfg_rdata ==
        {8'h06, 8'h04, 8'h00, SILICON_REVISION})
        else $error("class and revision word wrong");
    chk_perr_gate: assert property (
        primary_parity_err_pin_oe == $past(pe_hit))
        else $error("parity pin drive does not follow its cause");
    chk_perr_low: assert property (
        primary_parity_err_pin_oe |-> !primary_parity_err_pin_out)
        else $error("parity pin not driven low");
    chk_serr_fire: assert property (se_hit |=> primary_system_err_pin_oe
        && !primary_system_err_pin_out)
        else $error("system error pin not driven");
    chk_serr_gate: assert property (
        primary_system_err_pin_oe |-> $past(se_hit))
        else $error("system error pin driven without cause");
    chk_serr_flag: assert property (
        primary_system_err_pin_oe ##1 rd_cmd |=> cfg_rdata[30])
        else $error("signalled system error flag missing");
    chk_claim_decode: assert property (
        palette_claim == $past(pal_hit))
        else $error("palette claim wrong");
    chk_serr_enable: assert property (
        wr_l1 |=> serr_en == $past(cfg_req.wdata[8]))
        else $error("system error enable not written");

    cover property (rd_cls ##1 cfg_ack);
    cover property (se_hit);
    cover property (pal_hit && !io_write.in_io_window);
endmodule // bridge_cfg_checker

/* File: sim/cfg_host.sv */
// Configuration master model standing on the primary bus.
// Assumes the block answers one cycle after each taken request.
`timescale 1ns/1ns

module cfg_host (
    input wire logic sys_clk,
    output bridge_cfg_pkg::cfg_req_s cfg_req,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    initial cfg_req = '0;

    // one access with the given byte enables
    // Idle fields show inverted values so stale data is never trusted.
    task automatic access(input logic wr, input logic [7:0] addr,
            input logic [3:0] be_n, input logic [31:0] wd,
            input int gap, output logic [31:0] rd);
        @(negedge sys_clk);
        cfg_req = '{1'b1, wr, addr, be_n, wd};
        @(negedge sys_clk);
        rd = cfg_ack ? cfg_rdata : 32'hx;
        cfg_req = '{1'b0, ~wr, ~addr, ~be_n, ~wd};
        repeat (gap) @(negedge sys_clk);
    endtask
endmodule // cfg_host

/* File: sim/tb.sv */
// Self-checking bench for the primary configuration header block.
// Assumes cfg_host drives the register port; events come from here.
`timescale 1ns/1ns

module tb;
    localparam logic [7:0] REV = 8'h5c; // Arbitrary revision value.
    localparam logic [31:0] ST0 = 32'h02b0_0000; // Constant status bits.
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic primary_parity_err_pin_in = 1'b1; // Pulled up when idle.
    bridge_cfg_pkg::pri_event_s pri_event = '0;
    bridge_cfg_pkg::io_write_s io_write = '0;
    bridge_cfg_pkg::cfg_req_s cfg_req;
    logic cfg_ack, palette_claim, palette_snoop_en, parity_resp_en, serr_en;
    logic primary_parity_err_pin_out, primary_parity_err_pin_oe;
    logic primary_system_err_pin_out, primary_system_err_pin_oe;
    logic [31:0] cfg_rdata;
    logic s_perr, s_serr;
    int n_fail = 0;
    int n_tests = 0;

    always #20 sys_clk = ~sys_clk;

    bridge_primary_config_header #(.SILICON_REVISION(REV)) dut (.sys_clk,
        .resetn, .cfg_req, .cfg_ack, .cfg_rdata, .pri_event, .io_write,
        .palette_claim, .primary_parity_err_pin_in,
        .primary_parity_err_pin_out, .primary_parity_err_pin_oe,
        .primary_system_err_pin_out, .primary_system_err_pin_oe,
        .palette_snoop_en, .parity_resp_en, .serr_en);
    cfg_host host (.sys_clk, .cfg_req, .cfg_ack, .cfg_rdata);

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: %s", $time, what);
            n_fail++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.access(1'b0, a, 4'h0, 32'h0, 0, d);
        chk(d, exp, "register read");
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be_n,
            input logic [31:0] wd);
        logic [31:0] d;
        host.access(1'b1, a, be_n, wd, 1, d);
        chk(d, 32'h0, "write answer");
    endtask
    // Pulses one event and records both pin drives a cycle later.
    task automatic pulse(input bridge_cfg_pkg::pri_event_s ev);
        @(negedge sys_clk);
        pri_event = ev;
        @(negedge sys_clk);
        pri_event = '0;
        s_perr = primary_parity_err_pin_oe;
        s_serr = primary_system_err_pin_oe;
    endtask
    task automatic io(input logic [31:0] a, input logic win, input logic exp);
        @(negedge sys_clk);
        io_write = '{1'b1, a, win};
        @(negedge sys_clk);
        io_write = '{1'b0, ~a, 1'b0};
        chk({31'h0, palette_claim}, {31'h0, exp}, "palette claim");
    endtask

    task automatic t_reset;
        rd(8'h04, ST0);
        rd(8'h08,
            {8'h06, 8'h04, 8'h00, REV});
        rd(8'h0c, 32'h0);
        $display("test reset values done");
    endtask
    task automatic t_command;
        wr(8'h04, 4'h0, 32'h00ff_ffff);
        rd(8'h04, ST0 | 32'h0160);
        chk({29'h0, palette_snoop_en, parity_resp_en, serr_en},
            32'h7, "copies");
        wr(8'h04, 4'he, 32'h0);
        rd(8'h04, ST0 | 32'h0100);
        wr(8'h04, 4'hc, 32'h0160);
        $display("test command bits done");
    endtask
    task automatic t_errors;
        logic [31:0] d;
        pulse(6'h30);
        chk({31'h0, s_perr}, 32'h1, "parity pin");
        pulse(6'h04);
        pulse(6'h22);
        pulse(6'h21);
        pulse(6'h08);
        chk({31'h0, s_serr}, 32'h1, "system error pin");
        rd(8'h04,
            32'hfbb0_0160);
        wr(8'h04, 4'h7, 32'h8100_0000);
        rd(8'h04, 32'h7ab0_0160);
        wr(8'h04, 4'h7, 32'hff00_0000);
        rd(8'h04, ST0 | 32'h0160);
        @(negedge sys_clk);
        pri_event.master_active = 1'b1;
        primary_parity_err_pin_in = 1'b0;
        repeat (4) @(negedge sys_clk);
        pri_event.master_active = 1'b0;
        primary_parity_err_pin_in = 1'b1;
        repeat (3) @(negedge sys_clk);
        host.access(1'b0, 8'h04, 4'h0, 32'h0, 0, d);
        chk(d & 32'h0100_0000, 32'h0100_0000, "pin parity flag");
        wr(8'h04, 4'h7, 32'hff00_0000);
        $display("test error flags done");
    endtask
    task automatic t_no_resp;
        wr(8'h04, 4'hc, 32'h0100);
        pulse(6'h30);
        chk({31'h0, s_perr}, 32'h0, "parity pin off");
        pulse(6'h08);
        chk({31'h0, s_serr}, 32'h0, "system error off");
        rd(8'h04, 32'h82b0_0100);
        wr(8'h04, 4'hc, 32'h0040);
        pulse(6'h08);
        chk({31'h0, s_serr}, 32'h0, "system error gated");
        wr(8'h04, 4'h7, 32'hff00_0000);
        $display("test parity response off done");
    endtask
    task automatic t_palette;
        wr(8'h04, 4'hc, 32'h0020);
        io(32'h0000_ffc6, 1'b0, 1'b1);
        io(32'h0000_03c8, 1'b0, 1'b1);
        io(32'h0000_7bc9, 1'b0, 1'b1);
        io(32'h0000_03c7, 1'b0, 1'b0);
        io(32'h0001_03c6, 1'b0, 1'b0);
        wr(8'h04, 4'hc, 32'h0);
        io(32'h0000_03c6, 1'b0, 1'b0);
        io(32'h0000_03c6, 1'b1, 1'b1);
        $display("test palette decode done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        t_reset();
        t_command();
        t_errors();
        t_no_resp();
        t_palette();
        wrap_up();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #400000;
        n_fail++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        wrap_up();
    end
endmodule // tb

bind bridge_primary_config_header bridge_cfg_checker #(
    .SILICON_REVISION(SILICON_REVISION)
) watch (.sys_clk, .resetn, .cfg_req, .cfg_ack, .cfg_rdata, .pri_event,
    .io_write, .palette_claim, .primary_parity_err_pin_in,
    .primary_parity_err_pin_out, .primary_parity_err_pin_oe,
    .primary_system_err_pin_out, .primary_system_err_pin_oe,
    .palette_snoop_en, .parity_resp_en, .serr_en);
